//--- core/tcu8_pkg.sv
// package: constants, register map and carrier types of the 8-bit timer/counter
package tcu8_pkg;

    // ----------------------------------------
    // register byte addresses
    // ----------------------------------------
    localparam logic [3:0] tcu8_addr_ctrl = 4'h0;
    localparam logic [3:0] tcu8_addr_count = 4'h4;
    localparam logic [3:0] tcu8_addr_compare = 4'h8;
    localparam logic [3:0] tcu8_addr_flags = 4'hC;
    localparam logic [3:0] tcu8_addr_mask = 4'h0;

    // ----------------------------------------
    // control field positions
    // ----------------------------------------
    localparam int tcu8_pos_src = 0;
    localparam int tcu8_pos_wgm_high = 3;
    localparam int tcu8_pos_action = 4;
    localparam int tcu8_pos_wgm_low = 6;
    localparam int tcu8_pos_force = 7;
    localparam int tcu8_pos_global_ie = 8;

    // ----------------------------------------
    // flag bit positions
    // ----------------------------------------
    localparam int tcu8_pos_ovf = 6;
    localparam int tcu8_pos_cmp = 7;

    // ----------------------------------------
    // values and counts
    // ----------------------------------------
    localparam logic [7:0] tcu8_bottom = 8'h00;
    localparam logic [7:0] tcu8_max = 8'hFF;
    localparam logic [7:0] tcu8_reset_byte = 8'h00;
    localparam logic [2:0] tcu8_src_off = 3'h0;
    localparam logic [2:0] tcu8_src_clk = 3'h1;
    localparam logic [2:0] tcu8_src_div8 = 3'h2;
    localparam logic [2:0] tcu8_src_div64 = 3'h3;
    localparam logic [2:0] tcu8_src_div256 = 3'h4;
    localparam logic [2:0] tcu8_src_div1024 = 3'h5;
    localparam logic [2:0] tcu8_src_ext_fall = 3'h6;
    localparam logic [2:0] tcu8_src_ext_rise = 3'h7;
    localparam int tcu8_prescale_width = 10;
    localparam logic [1:0] tcu8_resp_okay = 2'h0;
    localparam logic [1:0] tcu8_resp_slverr = 2'h2;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        tcu8_mode_normal,
        tcu8_mode_pwm_phase,
        tcu8_mode_ctc,
        tcu8_mode_pwm_fast
    } tcu8_mode_t;

    typedef struct packed {
        logic global_ie;
        logic wgm_low;
        logic [1:0] action;
        logic wgm_high;
        logic [2:0] src;
    } tcu8_ctrl_t;

    typedef struct packed {
        logic compare_match_flag;
        logic overflow_flag;
    } tcu8_flags_t;

endpackage

//--- core/tcu8_timer.sv
// design: 8-bit timer/counter with one compare channel behind an axi4-lite slave
`timescale 1ns/100ps
`default_nettype none

module tcu8_timer #(
    parameter int addr_width = 4
) (
    // clock, enable, reset
    input wire logic clk,
    input wire logic clk_en,
    input wire logic rstn,
    // axi4-lite write address and data
    input wire logic [addr_width-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [addr_width-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // shared prescaler taps, one-cycle pulses
    input wire logic [3:0] prescale_tap,
    // external count pin and interrupt service
    input wire logic external_count_input,
    input wire logic compare_irq_ack,
    input wire logic overflow_irq_ack,
    // outputs
    output logic compare_output,
    output logic compare_irq,
    output logic overflow_irq
);

    initial begin
        if (addr_width < 4) begin
            $error("addr_width too small for the register map");
        end
    end

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_meta, rst_sync_n;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    tcu8_pkg::tcu8_ctrl_t ctrl;
    tcu8_pkg::tcu8_flags_t flags;
    logic [1:0] irq_mask;
    logic [7:0] timer_count_value;
    logic [7:0] compare_value;
    logic [7:0] compare_buffer;
    logic count_down;
    logic block_match;
    logic match_pending;
    logic ext_sync1, ext_sync2, ext_prev;

    tcu8_pkg::tcu8_mode_t mode;
    assign mode = tcu8_pkg::tcu8_mode_t'({ctrl.wgm_high, ctrl.wgm_low});
    logic pwm_mode;
    assign pwm_mode = mode == tcu8_pkg::tcu8_mode_pwm_fast || mode == tcu8_pkg::tcu8_mode_pwm_phase;

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    logic aw_held, w_held;
    logic [addr_width-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    assign s_axi_awready = clk_en && !aw_held && !s_axi_bvalid;
    assign s_axi_wready = clk_en && !w_held && !s_axi_bvalid;
    assign s_axi_arready = clk_en && !s_axi_rvalid;

    logic wr_fire;
    assign wr_fire = clk_en && aw_held && w_held && !s_axi_bvalid;
    logic [3:0] wr_addr;
    assign wr_addr = aw_addr[3:0];
    logic wr_ctrl, wr_count, wr_compare, wr_flags, wr_ok;
    assign wr_ok = aw_addr[addr_width-1:2] <= 3;
    assign wr_ctrl = wr_fire && wr_ok && wr_addr == tcu8_pkg::tcu8_addr_ctrl;
    assign wr_count = wr_fire && wr_ok && wr_addr == tcu8_pkg::tcu8_addr_count && w_strb[0];
    assign wr_compare = wr_fire && wr_ok && wr_addr == tcu8_pkg::tcu8_addr_compare && w_strb[0];
    assign wr_flags = wr_fire && wr_ok && wr_addr == tcu8_pkg::tcu8_addr_flags;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tcu8_pkg::tcu8_resp_okay;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? tcu8_pkg::tcu8_resp_okay : tcu8_pkg::tcu8_resp_slverr;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // reads return zero in unused bits; addresses from 0x10 up answer slverr
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h00000000;
        case (s_axi_araddr[3:0])
            tcu8_pkg::tcu8_addr_ctrl: begin
                next_rdata[8:0] = {ctrl.global_ie, 1'b0, ctrl.wgm_low, ctrl.action, ctrl.wgm_high, ctrl.src};
                next_rdata[17:16] = irq_mask;
            end
            tcu8_pkg::tcu8_addr_count: next_rdata[7:0] = timer_count_value;
            tcu8_pkg::tcu8_addr_compare: next_rdata[7:0] = pwm_mode ? compare_buffer : compare_value;
            tcu8_pkg::tcu8_addr_flags: begin
                next_rdata[tcu8_pkg::tcu8_pos_cmp] = flags.compare_match_flag;
                next_rdata[tcu8_pkg::tcu8_pos_ovf] = flags.overflow_flag;
            end
            default: next_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= tcu8_pkg::tcu8_resp_okay;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= (s_axi_araddr[addr_width-1:2] <= 3) ? next_rdata : 32'h00000000;
                s_axi_rresp <= (s_axi_araddr[addr_width-1:2] <= 3) ? tcu8_pkg::tcu8_resp_okay
                                                                   : tcu8_pkg::tcu8_resp_slverr;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // control and mask registers
    // ----------------------------------------
    logic force_strobe;
    assign force_strobe = wr_ctrl && w_strb[0] && w_data[tcu8_pkg::tcu8_pos_force] && !pwm_mode;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl <= '0;
            irq_mask <= 2'h0;
        end else if (clk_en && wr_ctrl) begin
            if (w_strb[0]) begin
                ctrl.src <= w_data[tcu8_pkg::tcu8_pos_src +: 3];
                ctrl.wgm_high <= w_data[tcu8_pkg::tcu8_pos_wgm_high];
                ctrl.action <= w_data[tcu8_pkg::tcu8_pos_action +: 2];
                ctrl.wgm_low <= w_data[tcu8_pkg::tcu8_pos_wgm_low];
            end
            if (w_strb[1]) begin
                ctrl.global_ie <= w_data[tcu8_pkg::tcu8_pos_global_ie];
            end
            if (w_strb[2]) begin
                irq_mask <= w_data[17:16];
            end
        end
    end

    // ----------------------------------------
    // tick selection
    // ----------------------------------------
    // the pin is taken synchronous; two stages still guard against slow edges
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
            ext_prev <= 1'b0;
        end else if (clk_en) begin
            ext_sync1 <= external_count_input;
            ext_sync2 <= ext_sync1;
            ext_prev <= ext_sync2;
        end
    end

    logic timer_tick;
    always_comb begin
        case (ctrl.src)
            tcu8_pkg::tcu8_src_off: timer_tick = 1'b0;
            tcu8_pkg::tcu8_src_clk: timer_tick = 1'b1;
            tcu8_pkg::tcu8_src_div8: timer_tick = prescale_tap[0];
            tcu8_pkg::tcu8_src_div64: timer_tick = prescale_tap[1];
            tcu8_pkg::tcu8_src_div256: timer_tick = prescale_tap[2];
            tcu8_pkg::tcu8_src_div1024: timer_tick = prescale_tap[3];
            tcu8_pkg::tcu8_src_ext_fall: timer_tick = ext_prev && !ext_sync2;
            tcu8_pkg::tcu8_src_ext_rise: timer_tick = !ext_prev && ext_sync2;
            default: timer_tick = 1'b0;
        endcase
    end

    // ----------------------------------------
    // counter
    // ----------------------------------------
    logic [7:0] top_value;
    assign top_value = (mode == tcu8_pkg::tcu8_mode_ctc) ? compare_value : tcu8_pkg::tcu8_max;
    logic at_top, at_bottom, equal;
    assign at_top = timer_count_value == top_value;
    assign at_bottom = timer_count_value == tcu8_pkg::tcu8_bottom;
    assign equal = timer_count_value == compare_value;

    logic [7:0] next_count;
    logic next_down;
    always_comb begin
        next_count = timer_count_value;
        next_down = count_down;
        case (mode)
            tcu8_pkg::tcu8_mode_normal: next_count = timer_count_value + 8'h01;
            tcu8_pkg::tcu8_mode_ctc: next_count = at_top ? tcu8_pkg::tcu8_bottom
                                                       : timer_count_value + 8'h01;
            tcu8_pkg::tcu8_mode_pwm_fast: next_count = at_top ? tcu8_pkg::tcu8_bottom
                                                            : timer_count_value + 8'h01;
            tcu8_pkg::tcu8_mode_pwm_phase: begin
                if (at_top) begin
                    next_down = 1'b1;
                end else if (at_bottom) begin
                    next_down = 1'b0;
                end
                next_count = next_down ? timer_count_value - 8'h01 : timer_count_value + 8'h01;
            end
            default: next_count = timer_count_value;
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            timer_count_value <= tcu8_pkg::tcu8_reset_byte;
            count_down <= 1'b0;
        end else if (clk_en) begin
            if (wr_count) begin
                timer_count_value <= w_data[7:0];
            end else if (timer_tick) begin
                timer_count_value <= next_count;
                count_down <= next_down;
            end
        end
    end

    // ----------------------------------------
    // compare register and buffer
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            compare_value <= tcu8_pkg::tcu8_reset_byte;
            compare_buffer <= tcu8_pkg::tcu8_reset_byte;
        end else if (clk_en) begin
            if (wr_compare) begin
                compare_buffer <= w_data[7:0];
                if (!pwm_mode) begin
                    compare_value <= w_data[7:0];
                end
            end
            if (pwm_mode && timer_tick && (at_top || at_bottom)) begin
                compare_value <= compare_buffer;
            end
        end
    end

    // ----------------------------------------
    // match, flags and output
    // ----------------------------------------
    // a counter write arms the block until the next tick, so a stopped timer stays blocked
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            block_match <= 1'b0;
            match_pending <= 1'b0;
        end else if (clk_en) begin
            if (wr_count) begin
                block_match <= 1'b1;
                match_pending <= 1'b0;
            end else if (timer_tick) begin
                block_match <= 1'b0;
                match_pending <= equal && !block_match;
            end
        end
    end

    logic match_event;
    assign match_event = timer_tick && match_pending;
    logic ovf_event;
    assign ovf_event = timer_tick && !wr_count && (pwm_mode ? (mode == tcu8_pkg::tcu8_mode_pwm_fast
                           ? at_top : at_bottom && count_down) : next_count == tcu8_pkg::tcu8_bottom
                           && timer_count_value == tcu8_pkg::tcu8_max);

    // set wins over software or service clear
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            flags <= '0;
        end else if (clk_en) begin
            if (match_event) begin
                flags.compare_match_flag <= 1'b1;
            end else if (compare_irq_ack || (wr_flags && w_strb[0] && w_data[tcu8_pkg::tcu8_pos_cmp])) begin
                flags.compare_match_flag <= 1'b0;
            end
            if (ovf_event) begin
                flags.overflow_flag <= 1'b1;
            end else if (overflow_irq_ack || (wr_flags && w_strb[0] && w_data[tcu8_pkg::tcu8_pos_ovf])) begin
                flags.overflow_flag <= 1'b0;
            end
        end
    end

    // mode changes leave the output register alone
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            compare_output <= 1'b0;
        end else if (clk_en && (match_event || force_strobe)) begin
            case (wr_ctrl && w_strb[0] ? w_data[tcu8_pkg::tcu8_pos_action +: 2] : ctrl.action)
                2'h1: compare_output <= pwm_mode ? compare_output : !compare_output;
                2'h2: compare_output <= 1'b0;
                2'h3: compare_output <= 1'b1;
                default: compare_output <= compare_output;
            endcase
        end
    end

    assign compare_irq = flags.compare_match_flag && irq_mask[1] && ctrl.global_ie;
    assign overflow_irq = flags.overflow_flag && irq_mask[0] && ctrl.global_ie;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    halt_hold_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        clk_en && ctrl.src == tcu8_pkg::tcu8_src_off && !wr_count |=> $stable(timer_count_value))
        else $error("counter moved while halted");
    write_prio_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        wr_count |=> timer_count_value == $past(w_data[7:0]))
        else $error("counter write lost");
    flag_set_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        clk_en && timer_tick && !wr_count && equal && !block_match ##1 clk_en && timer_tick
        |=> flags.compare_match_flag)
        else $error("match flag not set on next tick");
    write_block_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        wr_count ##1 (clk_en && timer_tick && !wr_count) ##1 (clk_en && timer_tick) |-> !match_event)
        else $error("match not blocked after counter write");
    irq_gate_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        match_event && clk_en && irq_mask[1] && ctrl.global_ie && !wr_ctrl |=> compare_irq)
        else $error("compare irq missing after match");
    ctc_clear_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        clk_en && timer_tick && !wr_count && mode == tcu8_pkg::tcu8_mode_ctc && equal
        |=> timer_count_value == tcu8_pkg::tcu8_bottom)
        else $error("ctc did not clear");
    wrap_ovf_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        clk_en && timer_tick && !wr_count && mode == tcu8_pkg::tcu8_mode_normal && timer_count_value == 8'hFF
        |=> timer_count_value == 8'h00 && flags.overflow_flag)
        else $error("normal wrap without overflow");
    force_noflag_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        force_strobe && !match_event && !flags.compare_match_flag |=> !flags.compare_match_flag)
        else $error("force set the match flag");
    buffer_hold_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        pwm_mode && !(clk_en && timer_tick && (at_top || at_bottom)) && !wr_ctrl |=> $stable(compare_value))
        else $error("active compare changed off top and bottom");

endmodule

`default_nettype wire

//--- test/tcu8_far_model.sv
// partner model: shared prescaler taps and external count pin
`timescale 1ns/100ps
`default_nettype none
module tcu8_far_model (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // pin burst request
    input wire logic pin_run,
    // far side outputs
    output logic [3:0] prescale_tap,
    output logic external_count_input
);
    logic [9:0] div;
    logic [1:0] ph;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div <= 10'h000;
            prescale_tap <= 4'h0;
        end else begin
            div <= div + 10'h001;
            prescale_tap <= {&div, &div[7:0], &div[5:0], &div[2:0]};
        end
    end
    // half period of four clocks keeps every edge sampleable; pin idles low between bursts
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ph <= 2'h0;
            external_count_input <= 1'b0;
        end else begin
            ph <= pin_run ? ph + 2'h1 : 2'h0;
            external_count_input <= pin_run ? external_count_input ^ (&ph) : 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- test/testbench.sv
// testbench: register bus, tick sources and compare unit of the 8-bit timer
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam logic [4:0] a_ctl = {1'b0, tcu8_pkg::tcu8_addr_ctrl};
    localparam logic [4:0] a_cnt = {1'b0, tcu8_pkg::tcu8_addr_count};
    localparam logic [4:0] a_cmp = {1'b0, tcu8_pkg::tcu8_addr_compare};
    localparam logic [4:0] a_flg = {1'b0, tcu8_pkg::tcu8_addr_flags};
    logic clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, cmp_ack = 1'b0, ovf_ack = 1'b0, pin_run = 1'b0, pin_q = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0, rd, rdata;
    logic awready, wready, bvalid, arready, rvalid, ext_pin, cmp_out, cmp_irq, ovf_irq;
    logic [1:0] bresp, rresp, rsp;
    logic [3:0] tap;
    logic [7:0] c;
    logic [9:0] acts = {2'h2, 2'h1, 2'h1, 2'h3, 2'h0};
    logic [4:0] outs = 5'h0B;
    int n_fail = 0, num_checks = 0, seed = 32'hF0036DC8, n_rise = 0, n_fall = 0, e0;
    int sh[4] = '{3, 6, 8, 10};
    always #5 clk = ~clk;
    always @(posedge clk) begin
        pin_q <= ext_pin;
        n_rise <= n_rise + int'(ext_pin && !pin_q);
        n_fall <= n_fall + int'(!ext_pin && pin_q);
    end
    tcu8_timer #(.addr_width(5)) i_dut (.clk(clk), .clk_en(clk_en), .rstn(rstn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .prescale_tap(tap), .external_count_input(ext_pin), .compare_irq_ack(cmp_ack),
        .overflow_irq_ack(ovf_ack), .compare_output(cmp_out), .compare_irq(cmp_irq), .overflow_irq(ovf_irq));
    tcu8_far_model i_far (.clk(clk), .rstn(rstn), .pin_run(pin_run), .prescale_tap(tap),
        .external_count_input(ext_pin));
    // ----------------------------------------
    // bus tasks and checks
    // ----------------------------------------
    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        rsp = bresp;
        bready <= 1'b0;
    endtask
    task rd_reg(input logic [4:0] a);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata; rsp = rresp;
        rready <= 1'b0;
    endtask
    function automatic logic [31:0] ctl(logic [2:0] s, logic [1:0] m, logic [1:0] act, logic f, logic [2:0] ie);
        ctl = {14'h0, ie[1:0], 7'h0, ie[2], f, m[0], act, m[1], s};
    endfunction
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #300000;
        n_fail++;
        final_report;
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            rd_reg(5'(4 * i));
            chk(rd, 32'h0);
        end
        wr(5'h10, 32'hFF);
        chk(32'(rsp), 32'(tcu8_pkg::tcu8_resp_slverr));
        wr(a_cnt, 32'h5A);
        rd_reg(5'h14);
        chk(rd, 32'h0);
        chk(32'(rsp), 32'(tcu8_pkg::tcu8_resp_slverr));
        for (int i = 0; i < 5; i++) begin
            wr(a_ctl, ctl(3'h0, 2'h0, acts[9-2*i -: 2], 1'b1, 3'h0));
            rd_reg(a_flg);
            chk(rd, 32'h0);
            chk(32'(cmp_out), 32'(outs[4-i]));
        end
        rd_reg(a_cnt);
        chk(rd, 32'h5A);
        wr(a_ctl, ctl(3'h0, 2'h3, 2'h0, 1'b0, 3'h0));
        wr(a_ctl, 32'h0);
        chk(32'(cmp_out), 32'h1);
        c = 8'($random(seed));
        wr(a_cmp, 32'(c));
        rd_reg(a_cmp);
        chk(rd, 32'(c));
        wr(a_ctl, ctl(3'h1, 2'h0, 2'h2, 1'b0, 3'h6));
        repeat (300) @(posedge clk);
        wr(a_ctl, ctl(3'h0, 2'h0, 2'h2, 1'b0, 3'h6));
        rd_reg(a_flg);
        chk(rd, 32'hC0);
        chk({cmp_out, cmp_irq, ovf_irq}, 32'h2);
        @(posedge clk) cmp_ack <= 1'b1;
        @(posedge clk) cmp_ack <= 1'b0;
        rd_reg(a_flg);
        chk({rd[30:0], cmp_irq}, 32'h80);
        wr(a_flg, 32'h40);
        rd_reg(a_flg);
        chk(rd, 32'h0);
        c = 8'h10 + (8'($random(seed)) & 8'h1F);
        wr(a_cmp, 32'(c));
        wr(a_cnt, 32'h0);
        wr(a_ctl, ctl(3'h1, 2'h2, 2'h0, 1'b0, 3'h0));
        repeat (300) @(posedge clk);
        wr(a_ctl, ctl(3'h0, 2'h2, 2'h0, 1'b0, 3'h0));
        rd_reg(a_cnt);
        chk(32'(rd <= 32'(c)), 32'h1);
        wr(a_flg, 32'hC0);
        rd_reg(a_flg);
        chk(rd, 32'h0);
        wr(a_cnt, 32'(c));
        wr(a_ctl, ctl(3'h1, 2'h0, 2'h0, 1'b0, 3'h0));
        wr(a_ctl, 32'h0);
        rd_reg(a_flg);
        chk(rd, 32'h0);
        wr(a_ctl, ctl(3'h0, 2'h3, 2'h0, 1'b0, 3'h0));
        wr(a_cmp, 32'h3C);
        rd_reg(a_cmp);
        chk(rd, 32'h3C);
        wr(a_ctl, 32'h0);
        rd_reg(a_cmp);
        chk(rd, 32'(c));
        wr(a_ctl, ctl(3'h1, 2'h3, 2'h0, 1'b0, 3'h0));
        repeat (300) @(posedge clk);
        wr(a_ctl, 32'h0);
        rd_reg(a_cmp);
        chk(rd, 32'h3C);
        wr(a_cnt, 32'h0);
        wr(a_ctl, ctl(3'h1, 2'h0, 2'h0, 1'b0, 3'h0));
        clk_en <= 1'b0;
        repeat (50) @(posedge clk);
        clk_en <= 1'b1;
        wr(a_ctl, 32'h0);
        rd_reg(a_cnt);
        chk(32'(rd < 32'h10), 32'h1);
        for (int s = 7; s > 5; s--) begin
            wr(a_cnt, 32'h0);
            wr(a_ctl, ctl(3'(s), 2'h0, 2'h0, 1'b0, 3'h0));
            e0 = (s == 7) ? n_rise : n_fall;
            pin_run <= 1'b1;
            repeat (40) @(posedge clk);
            pin_run <= 1'b0;
            repeat (10) @(posedge clk);
            wr(a_ctl, 32'h0);
            rd_reg(a_cnt);
            chk(rd, 32'((s == 7) ? n_rise - e0 : n_fall - e0));
        end
        for (int i = 0; i < 4; i++) begin
            wr(a_cnt, 32'h0);
            wr(a_ctl, ctl(3'(i + 2), 2'h0, 2'h0, 1'b0, 3'h0));
            repeat (1600) @(posedge clk);
            wr(a_ctl, 32'h0);
            rd_reg(a_cnt);
            chk(32'(rd - 32'(1600 >> sh[i]) <= 32'h2), 32'h1);
        end
        final_report;
    end
endmodule
`default_nettype wire
